// ---- hdl/flash_hub_mode_reset_control.sv ----
`timescale 1ns/1ps

// What this block does
// - Mode set by select pin alone.
// - Low: host link; high: mux.
// - Valid sequence launches an operation.
// - Machine times erase and program.
// - Either reset relocks all blocks.
// - Either reset clears status.
// - Init and reset act alike.
// - Reset blocks writes, stops machine, floats.
// - Outputs invalid until valid time.
// - Writes ignored until wake time.
// - Reset during busy adds latency.
// - Reset returns to read array.
// - No chip enable; protocol selects.
// - Host standby when frame high, idle.
// - Host link: five signals, byte cycles.
// - Array in equal 64 KB blocks.
// - Per-block read and write protection, host link only.
// - Two protect pins: boot, others.
// - Five host-readable general inputs.
// - Mux: 11 address, 8 data lines.
// - Host link synchronous to its clock.
// - Mux mode: read, clear status, program, erase.

// ====================================
// Mode, reset and command control of the flash hub.
// ====================================
module flash_hub_mode_reset_control
  import hub_ctl_pkg::*;
#(
  parameter int WAKE_CYCLES    = T_WAKE_CYC,         // Write wake count.
  parameter int VALID_CYCLES   = T_OUT_VALID_CYC,    // Output valid count.
  parameter int LATENCY_CYCLES = T_BUSY_LATENCY_CYC  // Busy reset latency.
) (
  input  wire logic                  clk,                  // System clock.
  input  wire logic                  rst_n,                // Async reset.
  input  wire logic                  if_reset_n,           // Interface reset.
  input  wire logic                  init_n,               // Processor init.
  input  wire logic                  interface_select_pin, // 0 host, 1 mux.
  input  wire logic                  frame_strobe_line,    // Host frame.
  input  wire logic [HOST_LINES-1:0] host_link_lines_in,   // Host lines in.
  input  wire cmd_write_t            host_wr,              // Decoded write.
  input  wire cmd_write_t            mux_wr,               // Mux write.
  input  wire logic                  mux_rd,               // Mux read.
  input  wire logic                  host_rd,              // Host read.
  input  wire logic [ADDR_W-1:0]     rd_addr,              // Read address.
  input  wire logic                  host_reg_wr,          // Lock reg write.
  input  wire logic [3:0]            host_reg_blk,         // Lock reg block.
  input  wire logic [1:0]            host_reg_val,         // Lock value.
  input  wire logic                  top_block_lock_n,     // Boot protect.
  input  wire logic                  write_protect_n,      // Other protect.
  input  wire logic [GP_W-1:0]       general_purpose_input,// Host readable.
  output logic [HOST_LINES-1:0]      host_link_lines_oe,   // Line enables.
  output logic                       host_mode,            // Host mode live.
  output logic                       mux_mode,             // Mux mode live.
  output logic                       outputs_valid,        // Outputs usable.
  output logic                       cmd_ready,            // Writes accepted.
  output logic                       standby,              // Low power.
  output logic                       array_read,           // Read array mode.
  output logic                       read_denied,          // Read blocked.
  output logic [DATA_W-1:0]          status_out,           // Status byte.
  output logic [GP_W-1:0]            gp_in,                // Latched inputs.
  output logic                       op_busy,              // Operation busy.
  output logic                       array_wr,             // Array commit.
  output logic [ADDR_W-1:0]          array_wr_addr,        // Commit address.
  output logic [DATA_W-1:0]          array_wr_data         // Commit data.
);

  // ====================================
  // Local functions.
  // ====================================

  // Block index of an array address: 64 KB blocks.
  function automatic logic [3:0] block_of(input logic [ADDR_W-1:0] a);
    block_of = a[BLOCK_AW +: 4];
  endfunction : block_of

  // Counter load, at least one.
  function automatic logic [15:0] cyc(input int n);
    cyc = (n < 1) ? 16'h0001 : 16'(n);
  endfunction : cyc

  // ====================================
  // Declarations.
  // ====================================
  logic             dev_rst;                 // Combined reset, active high.
  logic             rst_d_reg;               // Reset seen last cycle.
  logic             release_pulse;           // Reset just released.
  mode_t            mode_reg;                // Interface mode.
  logic [15:0]      wake_reg;                // Cycles to write wake.
  logic [15:0]      valid_reg;               // Cycles to output valid.
  logic             hit_busy_reg;            // Reset struck a busy op.
  logic [1:0]       lock_reg [NUM_BLOCKS];   // Bit0 write, bit1 read lock.
  read_mode_t       rmode_reg;               // Read mode.
  logic [DATA_W-1:0] status_reg;             // Status register.
  logic             erase_pend_reg;          // Erase setup seen.
  logic             prog_pend_reg;           // Program setup seen.
  cmd_write_t       wr;                      // Selected write.
  op_req_t          req_reg;                 // Request to the machine.
  logic             op_run;                  // Machine busy.
  logic             op_end;                  // Machine done pulse.
  logic             wr_blocked;              // Write to protected block.

  // Both reset inputs act alike.
  assign dev_rst = !if_reset_n || !init_n;
  assign release_pulse = rst_d_reg && !dev_rst;

  // Only the active port's writes reach the interpreter.
  // No chip enable: a valid cycle alone selects.
  assign wr = (mode_reg == MODE_MUX) ? mux_wr : host_wr;

  // Refused by its lock bit (host mode only) or its protect pin.
  assign wr_blocked = lock_reg[block_of(wr.addr)][0] && (mode_reg == MODE_HOST)
                    || (block_of(wr.addr) == 4'(NUM_BLOCKS - 1)
                        ? !top_block_lock_n : !write_protect_n);

  // ====================================
  // Reset tracking and mode capture.
  // ====================================

  // Mode comes from the pin level at release, then holds.
  // The board keeps that level stable then.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_d_reg <= 1'b1;
      mode_reg  <= MODE_HOST;
    end else begin
      rst_d_reg <= dev_rst;
      if (release_pulse) begin
        // Low picks the host link, high the mux interface.
        mode_reg <= interface_select_pin ? MODE_MUX : MODE_HOST;
      end
    end
  end

  // An aborted operation lengthens recovery.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hit_busy_reg <= 1'b0;
    end else if (dev_rst && op_run) begin
      hit_busy_reg <= 1'b1;
    end else if (release_pulse) begin
      hit_busy_reg <= 1'b0;
    end
  end

  // Counters load on release, plus the busy latency if the reset aborted an operation, so neither
  // beats the recovering array.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_reg  <= 16'hffff;
      valid_reg <= 16'hffff;
    end else if (dev_rst) begin
      wake_reg  <= 16'hffff;
      valid_reg <= 16'hffff;
    end else if (release_pulse) begin
      wake_reg  <= cyc(WAKE_CYCLES + (hit_busy_reg ? LATENCY_CYCLES : 0));
      valid_reg <= cyc(VALID_CYCLES + (hit_busy_reg ? LATENCY_CYCLES : 0));
    end else begin
      if (wake_reg != 16'h0000) wake_reg <= wake_reg - 16'h0001;
      if (valid_reg != 16'h0000) valid_reg <= valid_reg - 16'h0001;
    end
  end

  // ====================================
  // Block locks.
  // ====================================

  // Reset relocks writes; only the host link may edit
  // the locks.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_BLOCKS; i++) lock_reg[i] <= LOCK_RESET;
    end else if (dev_rst) begin
      for (int i = 0; i < NUM_BLOCKS; i++) lock_reg[i] <= LOCK_RESET;
    end else if (host_reg_wr && mode_reg == MODE_HOST && cmd_ready) begin
      lock_reg[host_reg_blk] <= host_reg_val;
    end
  end

  // ====================================
  // Command interpreter.
  // ====================================

  // A full sequence launches the machine; writes drop in
  // reset and before wake.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rmode_reg      <= RD_ARRAY;
      erase_pend_reg <= 1'b0;
      prog_pend_reg  <= 1'b0;
      req_reg        <= '0;
    end else if (dev_rst) begin
      rmode_reg      <= RD_ARRAY;  // Back to read array.
      erase_pend_reg <= 1'b0;
      prog_pend_reg  <= 1'b0;
      req_reg        <= '0;
    end else begin
      req_reg.start <= 1'b0;
      if (wr.valid && wake_reg == 16'h0000 && !op_run) begin
        if (prog_pend_reg) begin
          prog_pend_reg <= 1'b0;
          rmode_reg     <= RD_STATUS;
          if (!wr_blocked) begin
            req_reg <= '{start: 1'b1, kind: OP_PROGRAM,
                         addr: wr.addr, data: wr.data};
          end
        end else if (erase_pend_reg) begin
          erase_pend_reg <= 1'b0;
          rmode_reg      <= RD_STATUS;
          if (wr.data == CMD_ERASE_CONF && !wr_blocked) begin
            req_reg <= '{start: 1'b1, kind: OP_ERASE,
                         addr: wr.addr, data: 8'hff};
          end
        end else begin
          case (wr.data)
            CMD_READ_ARRAY:  rmode_reg <= RD_ARRAY;
            CMD_READ_STATUS: rmode_reg <= RD_STATUS;
            CMD_ERASE_SETUP: erase_pend_reg <= 1'b1;
            CMD_PROGRAM:     prog_pend_reg <= 1'b1;
            default:         rmode_reg <= rmode_reg;
          endcase
        end
      end
    end
  end

  // Reset clears status; refusals set error bits.
  // A set beats a clear in one cycle.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_reg <= STATUS_RESET;
    end else if (dev_rst) begin
      status_reg <= STATUS_RESET;
    end else begin
      if (wr.valid && wake_reg == 16'h0000 && !op_run
          && !erase_pend_reg && !prog_pend_reg
          && wr.data == CMD_CLEAR_STATUS) begin
        status_reg[STAT_ERASE_ERR:STAT_SEQ_ERR] <= 3'h0;
      end
      if (wr.valid && wake_reg == 16'h0000 && !op_run) begin
        if (erase_pend_reg && wr.data != CMD_ERASE_CONF) begin
          status_reg[STAT_ERASE_ERR] <= 1'b1;
          status_reg[STAT_SEQ_ERR]   <= 1'b1;
        end else if (erase_pend_reg && wr_blocked) begin
          status_reg[STAT_ERASE_ERR] <= 1'b1;
        end else if (prog_pend_reg && wr_blocked) begin
          status_reg[STAT_PROG_ERR] <= 1'b1;
        end
      end
      status_reg[STAT_READY_BIT] <= !(op_run || req_reg.start);
    end
  end

  write_state_machine u_mach (
    .clk   (clk),
    .rst_n (rst_n),
    .abort (dev_rst),
    .req   (req_reg),
    .busy  (op_run),
    .done  (op_end)
  );

  // ====================================
  // Registered outputs.
  // ====================================

  // Lines float in reset, mux mode and between reads.
  // Five host signals: these four and the frame.
  // Host timing is resampled to this clock upstream.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      host_link_lines_oe <= '0;
    end else begin
      host_link_lines_oe <= (!dev_rst && mode_reg == MODE_HOST && host_rd
                             && valid_reg == 16'h0000) ? '1 : '0;
    end
  end

  // Mode flags, readiness and standby indication.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      host_mode     <= 1'b0;
      mux_mode      <= 1'b0;
      outputs_valid <= 1'b0;
      cmd_ready     <= 1'b0;
      standby       <= 1'b0;
      array_read    <= 1'b1;
      read_denied   <= 1'b0;
      status_out    <= STATUS_RESET;
      gp_in         <= '0;
      op_busy       <= 1'b0;
    end else begin
      // Hidden on the release edge, while the new mode loads.
      host_mode     <= !dev_rst && !release_pulse && mode_reg == MODE_HOST;
      mux_mode      <= !dev_rst && !release_pulse && mode_reg == MODE_MUX;
      outputs_valid <= !dev_rst && valid_reg == 16'h0000;
      cmd_ready     <= !dev_rst && wake_reg == 16'h0000;
      // Host mode, frame high, idle: standby.
      standby       <= mode_reg == MODE_HOST && frame_strobe_line
                       && !op_run && !req_reg.start && !host_rd;
      array_read    <= rmode_reg == RD_ARRAY;
      // Read lock applies only on the host link.
      read_denied   <= mode_reg == MODE_HOST && (host_rd || mux_rd)
                       && lock_reg[block_of(rd_addr)][1];
      status_out    <= status_reg;
      // Host side only.
      gp_in         <= (mode_reg == MODE_HOST) ? general_purpose_input : '0;
      op_busy       <= op_run;
    end
  end

  // Commit when an operation finishes unaborted.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      array_wr      <= 1'b0;
      array_wr_addr <= '0;
      array_wr_data <= '0;
    end else begin
      array_wr      <= op_end;
      array_wr_addr <= req_reg.addr;
      array_wr_data <= req_reg.data;
    end
  end

endmodule : flash_hub_mode_reset_control

// ---- hdl/hub_ctl_pkg.sv ----
package hub_ctl_pkg;

  // ==========================================================================
  // Clock and timing.
  // ==========================================================================
  localparam int CLK_PERIOD_PS      = 8000;   // 125 MHz system clock.
  localparam int T_OUT_VALID_NS     = 1000;   // Reset to output valid time.
  localparam int T_WAKE_NS          = 1000;   // Reset to write wake time.
  localparam int T_BUSY_LATENCY_NS  = 20000;  // Extra latency, reset in busy.
  localparam int T_OUT_VALID_CYC    = (T_OUT_VALID_NS * 1000 +
                                       CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int T_WAKE_CYC         = (T_WAKE_NS * 1000 +
                                       CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int T_BUSY_LATENCY_CYC = (T_BUSY_LATENCY_NS * 1000 +
                                       CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ERASE_CYC          = 64;     // Internal erase duration.
  localparam int PROGRAM_CYC        = 16;     // Internal program duration.

  // ==========================================================================
  // Geometry and widths.
  // ==========================================================================
  localparam int NUM_BLOCKS    = 16;   // Number of 64 KB blocks.
  localparam int BLOCK_AW      = 16;   // Byte address bits inside a block.
  localparam int ADDR_W        = 20;   // Array byte address width.
  localparam int HOST_LINES    = 4;    // Host link data lines.
  localparam int GP_W          = 5;    // General purpose inputs.
  localparam int MUX_ADDR_W    = 11;   // Multiplexed address inputs.
  localparam int DATA_W        = 8;    // Byte wide data.

  // ==========================================================================
  // Command codes and status bits.
  // ==========================================================================
  localparam logic [7:0] CMD_READ_ARRAY   = 8'hff;
  localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_ERASE_SETUP  = 8'h20;
  localparam logic [7:0] CMD_ERASE_CONF   = 8'hd0;
  localparam logic [7:0] CMD_PROGRAM      = 8'h40;
  localparam logic [7:0] STATUS_RESET     = 8'h80;  // Ready, no errors.
  localparam int STAT_READY_BIT   = 7;
  localparam int STAT_ERASE_ERR   = 5;
  localparam int STAT_PROG_ERR    = 4;
  localparam int STAT_SEQ_ERR     = 3;
  localparam logic [1:0] LOCK_RESET = 2'h1;  // Write locked, read open.

  // ==========================================================================
  // Types.
  // ==========================================================================
  typedef enum logic {MODE_HOST, MODE_MUX} mode_t;

  typedef enum logic [1:0] {
    RD_ARRAY, RD_STATUS
  } read_mode_t;

  typedef enum logic [1:0] {
    OP_NONE, OP_ERASE, OP_PROGRAM
  } op_kind_t;

  // One byte write toward the command interpreter.
  typedef struct packed {
    logic              valid;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } cmd_write_t;

  // Request from the interpreter to the write state machine.
  typedef struct packed {
    logic              start;
    op_kind_t          kind;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } op_req_t;

endpackage : hub_ctl_pkg

// ---- hdl/write_state_machine.sv ----
`timescale 1ns/1ps

// ============================================================================
// Write state machine: times erase and program on its own.
// ============================================================================
module write_state_machine
  import hub_ctl_pkg::*;
#(
  parameter int ERASE_CYCLES   = ERASE_CYC,    // Erase duration.
  parameter int PROGRAM_CYCLES = PROGRAM_CYC   // Program duration.
) (
  input  wire logic    clk,        // System clock.
  input  wire logic    rst_n,      // Async reset, active low.
  input  wire logic    abort,      // Combined device reset, synchronous.
  input  wire op_req_t req,        // Operation request.
  output logic         busy,       // Operation in progress.
  output logic         done        // One-cycle completion pulse.
);

  typedef enum logic {W_IDLE, W_RUN} m_state_t;

  m_state_t    state_reg;          // Current state.
  logic [15:0] count_reg;          // Cycles left in the operation.

  assign busy = (state_reg == W_RUN);

  // Runs on its own; an abort drops the operation.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= W_IDLE;
      count_reg <= 16'h0000;
      done      <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state_reg)
        W_IDLE: begin
          if (req.start && !abort) begin
            state_reg <= W_RUN;
            // Erase runs longer than program.
            count_reg <= (req.kind == OP_ERASE) ? 16'(ERASE_CYCLES)
                                               : 16'(PROGRAM_CYCLES);
          end
        end
        W_RUN: begin
          if (abort) begin
            state_reg <= W_IDLE;  // Reset stops the automation.
          end else if (count_reg <= 16'h0001) begin
            state_reg <= W_IDLE;
            done      <= 1'b1;
          end else begin
            count_reg <= count_reg - 16'h0001;
          end
        end
        default: begin
          state_reg <= W_IDLE;
        end
      endcase
    end
  end

endmodule : write_state_machine

// ---- sim/hub_ctl_monitor.sv ----
`timescale 1ns/1ps

// ============================================================================
// Port checker for mode and reset control.
// ============================================================================
module hub_ctl_monitor
  import hub_ctl_pkg::*;
#(
  parameter int WAKE_CYCLES  = 4,  // Write wake count.
  parameter int VALID_CYCLES = 4   // Output valid count.
) (
  input wire logic                  clk,                // System clock.
  input wire logic                  rst_n,              // Async reset.
  input wire logic                  if_reset_n,         // Interface reset.
  input wire logic                  init_n,             // Processor init.
  input wire logic                  frame_strobe_line,  // Host frame.
  input wire logic [HOST_LINES-1:0] host_link_lines_oe, // Line enables.
  input wire logic                  host_mode,          // Host mode.
  input wire logic                  mux_mode,           // Mux mode.
  input wire logic                  outputs_valid,      // Outputs usable.
  input wire logic                  cmd_ready,          // Writes taken.
  input wire logic                  standby,            // Low power.
  input wire logic                  array_read,         // Read array.
  input wire logic [DATA_W-1:0]     status_out,         // Status byte.
  input wire logic [GP_W-1:0]       gp_in,              // Latched inputs.
  input wire logic                  op_busy,            // Busy.
  input wire logic                  array_wr            // Commit pulse.
);
  logic [5:0] cnt_reg;  // Edges since reset release.

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Time out of reset; saturates rather than wrap.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) cnt_reg <= '0;
    else if (!(if_reset_n && init_n)) cnt_reg <= '0;
    else if (cnt_reg != 6'h3f) cnt_reg <= cnt_reg + 6'h01;
  end

  a_status_clear: assert property (!(if_reset_n && init_n) |-> ##2
    status_out == STATUS_RESET) else $error("status not cleared");
  a_reset_float: assert property (!if_reset_n |=>
    host_link_lines_oe == '0 && !cmd_ready) else $error("lines driven");
  a_init_array: assert property (!init_n |=> !cmd_ready ##1
    array_read) else $error("init reset differs");
  a_mux_quiet: assert property (mux_mode |-> !host_mode &&
    gp_in == '0 && host_link_lines_oe == '0) else $error("mux leak");
  a_mode_hold: assert property (host_mode && if_reset_n &&
    init_n |=> host_mode) else $error("mode changed");
  a_standby_frame: assert property (standby && host_mode |->
    $past(frame_strobe_line)) else $error("standby in frame");
  a_commit_pulse: assert property (array_wr |=> !array_wr)
    else $error("commit not one cycle");
  a_busy_commit: assert property (@(posedge clk)
    disable iff (!rst_n || !if_reset_n || !init_n)
    $rose(op_busy) |-> ##[1:80] array_wr) else $error("no commit");
  a_wake_hold: assert property (cmd_ready |->
    cnt_reg >= WAKE_CYCLES) else $error("writes taken early");
  a_valid_late: assert property (outputs_valid |->
    cnt_reg >= VALID_CYCLES) else $error("outputs valid early");
  a_valid_bound: assert property (cnt_reg == 6'h3c |->
    outputs_valid) else $error("outputs never valid");
endmodule : hub_ctl_monitor

bind flash_hub_mode_reset_control hub_ctl_monitor #(
  .WAKE_CYCLES(WAKE_CYCLES), .VALID_CYCLES(VALID_CYCLES)) mon (.*);

// ---- sim/cmd_source.sv ----
`timescale 1ns/1ps

// ============================================================================
// Host or programmer issuing command bytes.
// ============================================================================
module cmd_source
  import hub_ctl_pkg::*;
(
  input  wire logic clk,        // System clock.
  input  wire logic cmd_ready,  // Device accepts writes.
  output cmd_write_t host_wr,   // Host port write.
  output cmd_write_t mux_wr     // Mux port write.
);
  initial begin
    host_wr = '0;
    mux_wr  = '0;
  end

  // One-cycle write; the bus then shows inverted junk.
  task automatic wr(input logic sel, input logic [ADDR_W-1:0] a,
                    input logic [DATA_W-1:0] d);
    for (int i = 0; i < 200 && !cmd_ready; i++) @(negedge clk);
    @(negedge clk);
    if (sel) mux_wr = '{1'b1, a, d};
    else host_wr = '{1'b1, a, d};
    @(negedge clk);
    host_wr = '{1'b0, ~a, ~d};
    mux_wr  = '{1'b0, ~a, ~d};
  endtask : wr
endmodule : cmd_source

// ---- sim/testbench.sv ----
`timescale 1ns/1ps

// ============================================================================
// Self-checking bench for mode and reset control.
// ============================================================================
module testbench;
  import hub_ctl_pkg::*;
  localparam int LAT = 16;  // Short busy latency.
  logic clk, rst_n, if_reset_n, init_n, interface_select_pin;
  logic frame_strobe_line, mux_rd, host_rd, host_reg_wr;
  logic top_block_lock_n, write_protect_n, host_mode, mux_mode;
  logic outputs_valid, cmd_ready, standby, array_read, read_denied;
  logic op_busy, array_wr;
  logic [HOST_LINES-1:0] host_link_lines_in, host_link_lines_oe;
  logic [ADDR_W-1:0]     rd_addr, array_wr_addr;
  logic [3:0]            host_reg_blk;
  logic [1:0]            host_reg_val;
  logic [GP_W-1:0]       general_purpose_input, gp_in;
  logic [DATA_W-1:0]     status_out, array_wr_data;
  cmd_write_t            host_wr, mux_wr;
  int                    err_total, cmp_count, n0, n1;

  flash_hub_mode_reset_control #(.WAKE_CYCLES(4), .VALID_CYCLES(4),
    .LATENCY_CYCLES(LAT)) dut (.*);
  cmd_source src (.*);

  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end

  // ==========================================================================
  // Shared tasks.
  // ==========================================================================
  task automatic chk(input logic [19:0] e, g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk

  // Select settles before reset returns high.
  task automatic do_reset(input logic sel, output int n);
    @(negedge clk);
    interface_select_pin = sel;
    if_reset_n = 0;
    repeat (3) @(negedge clk);
    if_reset_n = 1;
    for (n = 0; n < 200 && !cmd_ready; n++) @(negedge clk);
  endtask : do_reset

  task automatic unlock0();
    @(negedge clk);
    {host_reg_wr, host_reg_blk, host_reg_val} = {1'b1, 4'h0, 2'h0};
    @(negedge clk);
    host_reg_wr = 0;
  endtask : unlock0

  task automatic wait_commit();
    for (int i = 0; i < 200 && !array_wr; i++) @(negedge clk);
  endtask : wait_commit

  // ==========================================================================
  // Scenarios.
  // ==========================================================================
  task automatic t_modes();
    for (int s = 0; s < 2; s++) begin
      do_reset(s[0], n0);
      chk(s, mux_mode);
      chk(!s, host_mode);
      chk(1, array_read);
      chk(STATUS_RESET, status_out);
      interface_select_pin = !s[0];
      repeat (3) @(negedge clk);
      chk(s, mux_mode);
      chk(s ? 0 : general_purpose_input, gp_in);
    end
  endtask : t_modes

  task automatic t_program(input logic sel);
    do_reset(sel, n0);
    if (!sel) unlock0();
    src.wr(sel, 20'h00123, CMD_PROGRAM);
    src.wr(sel, 20'h00123, 8'h5a);
    wait_commit();
    chk(20'h00123, array_wr_addr);
    chk(8'h5a, array_wr_data);
  endtask : t_program

  task automatic t_locked();
    do_reset(0, n0);
    src.wr(0, 20'h30000, CMD_PROGRAM);
    src.wr(0, 20'h30000, 8'h11);
    repeat (30) @(negedge clk);
    chk(1, status_out[STAT_PROG_ERR]);
    init_n = 0;
    repeat (2) @(negedge clk);
    init_n = 1;
    repeat (3) @(negedge clk);
    chk(STATUS_RESET, status_out);
    do_reset(1, n0);
    top_block_lock_n = 0;
    src.wr(1, 20'hf0010, CMD_PROGRAM);
    src.wr(1, 20'hf0010, 8'h22);
    repeat (30) @(negedge clk);
    chk(1, status_out[STAT_PROG_ERR]);
    top_block_lock_n = 1;
    src.wr(1, 20'h0, CMD_ERASE_SETUP);
    src.wr(1, 20'h0, 8'h00);
    repeat (4) @(negedge clk);
    chk(2'b11, {status_out[STAT_ERASE_ERR], status_out[STAT_SEQ_ERR]});
  endtask : t_locked

  task automatic t_busy_reset();
    do_reset(0, n0);
    unlock0();
    src.wr(0, 20'h0, CMD_ERASE_SETUP);
    src.wr(0, 20'h0, CMD_ERASE_CONF);
    repeat (4) @(negedge clk);
    chk(1, op_busy);
    do_reset(0, n1);
    chk(1, n1 >= n0 + LAT);
    chk(0, op_busy);
    frame_strobe_line = 1;
    repeat (3) @(negedge clk);
    chk(1, standby);
    frame_strobe_line = 0;
    repeat (3) @(negedge clk);
    chk(0, standby);
    host_rd = 1;
    repeat (2) @(negedge clk);
    chk(4'hf, host_link_lines_oe);
    chk(0, read_denied);
    host_rd = 0;
  endtask : t_busy_reset

  task automatic wrap_up();
    $display("errors=%0d compares=%0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  initial begin
    {rst_n, if_reset_n, init_n, interface_select_pin} = 4'b0110;
    {frame_strobe_line, mux_rd, host_rd, host_reg_wr} = 4'h0;
    {top_block_lock_n, write_protect_n} = 2'b11;
    {host_link_lines_in, rd_addr, host_reg_blk, host_reg_val} = '0;
    general_purpose_input = 5'h15;
    {err_total, cmp_count} = 0;
    repeat (12) @(negedge clk);
    rst_n = 1;
    t_modes();
    t_program(0);
    t_program(1);
    t_locked();
    t_busy_reset();
    wrap_up();
  end

  // Hang guard, far past the few hundred cycles needed.
  initial begin
    #(8 * 20000);
    err_total++;
    wrap_up();
  end
endmodule : testbench
